// ===== shared/spi_cmd_pkg.sv
package spi_cmd_pkg;
   localparam logic [7:0] IDLE_CODE = 8'h55;
   localparam logic [7:0] NULL_CODE = 8'h00;
   localparam logic [7:0] SETUPS_CODE = 8'h01;
   localparam logic [7:0] ALL_KEYS_CODE = 8'hC1;
   localparam logic [3:0] SET_GROUP = 4'h9;
   localparam logic [3:0] GET_GROUP = 4'hA;
   localparam logic [3:0] REPORT_GROUP = 4'hC;
   localparam int SETUP_LEN = 42;
   localparam logic [5:0] REPORT_LEN = 6'h02;
   localparam logic [5:0] GET_LEN = 6'h01;
   localparam logic [5:0] SET_HOST_LEN = 6'h02;
   localparam logic [5:0] ONE_BYTE = 6'h01;
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [7:0] CRC_POLY_DEF = 8'h07;
   localparam logic [7:0] CRC_INIT_DEF = 8'h00;
   localparam int CLK_MHZ = 100;
   localparam int SCK_MAX_KHZ = 1500;
   localparam int SCK_HALF_CYC =
      (CLK_MHZ * 1000 + 2 * SCK_MAX_KHZ - 1) / (2 * SCK_MAX_KHZ);
   localparam int GAP_US = 150;
   localparam int GAP_CYC = GAP_US * CLK_MHZ;
   localparam int TIMEOUT_MS = 100;
   localparam int TIMEOUT_CYC = TIMEOUT_MS * 1000 * CLK_MHZ;

   typedef enum logic [2:0] {
      CL_CTRL, CL_SETUPS, CL_REPORT, CL_SET, CL_GET
   } cmd_class_t;

   function automatic cmd_class_t classify(input logic [7:0] c);
      if (c == SETUPS_CODE) return CL_SETUPS;
      if (c[7:4] == SET_GROUP) return CL_SET;
      if (c[7:4] == GET_GROUP) return CL_GET;
      if (c[7:4] == REPORT_GROUP) return CL_REPORT;
      return CL_CTRL;
   endfunction

   // Bytes the host contributes, command byte included.
   function automatic logic [5:0] host_len(input cmd_class_t c);
      if (c == CL_SETUPS) return 6'(SETUP_LEN) + ONE_BYTE;
      if (c == CL_SET) return SET_HOST_LEN;
      return ONE_BYTE;
   endfunction

   function automatic logic [5:0] resp_len(input cmd_class_t c);
      if (c == CL_REPORT) return REPORT_LEN;
      if (c == CL_GET) return GET_LEN;
      return 6'h00;
   endfunction

   function automatic logic [5:0] total_len(input cmd_class_t c,
                                            input logic en);
      logic [5:0] r;
      r = resp_len(c);
      return host_len(c) + r + {5'h00, en} + {5'h00, en && (r != 6'h00)};
   endfunction

   function automatic logic [7:0] crc8(input logic [7:0] crc,
                                       input logic [7:0] d,
                                       input logic [7:0] poly);
      logic [7:0] c;
      c = crc ^ d;
      for (int i = 0; i < 8; i++) begin
         c = c[7] ? ({c[6:0], 1'h0} ^ poly) : {c[6:0], 1'h0};
      end
      return c;
   endfunction
endpackage

// ===== shared/spi_link_if.sv
`timescale 1ns/1ps
interface spi_link_if;
   logic sck;
   logic ss_n;
   logic mosi;
   logic miso_drv;
   logic miso_oe_n;
   logic miso;

   // MISO is pulled high while the device does not drive it.
   assign miso = miso_oe_n ? 1'h1 : miso_drv;

   modport device (
      input sck,
      input ss_n,
      input mosi,
      output miso_drv,
      output miso_oe_n
   );
   modport host (
      output sck,
      output ss_n,
      output mosi,
      input miso
   );
endinterface

// ===== hdl/byte_fifo2.sv
`timescale 1ns/1ps
module byte_fifo2 #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 2
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic in_valid_i,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic in_ready_o,
   output logic out_valid_o,
   output logic [WIDTH-1:0] out_data_o,
   input wire logic out_ready_i
);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [DEPTH-1:0] vld;
   } fifo_t;

   fifo_t q_r, q_nxt;

   // Entry zero is always the head, so the output is a plain register.
   always_comb begin
      logic placed;
      placed = 1'h0;
      q_nxt = q_r;
      if (q_r.vld[0] && out_ready_i) begin
         for (int i = 0; i < DEPTH - 1; i++) begin
            q_nxt.mem[i] = q_r.mem[i+1];
            q_nxt.vld[i] = q_r.vld[i+1];
         end
         q_nxt.vld[DEPTH-1] = 1'h0;
      end
      for (int i = 0; i < DEPTH; i++) begin
         if (in_valid_i && !q_r.vld[DEPTH-1] && !placed && !q_nxt.vld[i]) begin
            q_nxt.mem[i] = in_data_i;
            q_nxt.vld[i] = 1'h1;
            placed = 1'h1;
         end
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         q_r <= '0;
      end else begin
         q_r <= q_nxt;
      end
   end

   assign in_ready_o = !q_r.vld[DEPTH-1];
   assign out_valid_o = q_r.vld[0];
   assign out_data_o = q_r.mem[0];
endmodule // byte_fifo2

// ===== hdl/spi_cmd_device.sv
`timescale 1ns/1ps
// Notes on behaviour
// - One byte per select, eight clocks, MSB first.
// - Clock idles high; change falling, sample rising.
// - Host keeps serial clock at most 1.5 MHz.
// - Host waits 150 us between bytes.
// - Over 100 ms gap discards partial transaction.
// - Idle code on first byte of command.
// - Checksum verified before any command acts.
// - Device returns expected checksum during checksum byte.
// - Returned data followed by its checksum.
// - Host sends null bytes while reading.
// - Control command is one byte, no response.
// - Setup load halts sensing, takes 42 bytes.
// - Report returns two bytes after idle code.
// - Set echoes its command on second byte.
// - Set data written only after checksum verified.
// - Set code carries the target location.
// - Get returns the addressed location's contents.
module spi_cmd_device #(
   parameter logic [7:0] CRC_POLY = spi_cmd_pkg::CRC_POLY_DEF,
   parameter logic [7:0] CRC_INIT = spi_cmd_pkg::CRC_INIT_DEF,
   parameter int TIMEOUT_CYC = spi_cmd_pkg::TIMEOUT_CYC
) (
   input wire logic clk_i,
   input wire logic rst_i,
   spi_link_if.device link,
   input wire logic crc_en_i,
   input wire logic [15:0] key_status_i,
   output logic ctrl_valid_o,
   output logic [7:0] ctrl_code_o,
   output logic sensing_halt_o,
   output logic setup_apply_o,
   output logic crc_err_o,
   output logic [spi_cmd_pkg::SETUP_LEN-1:0][7:0] cfg_o
);
   typedef struct packed {
      logic [7:0] sh;
      logic [7:0] rx;
      logic tgl;
   } lnk_t;

   typedef struct packed {
      logic miso;
      logic oe_n;
   } drv_t;

   typedef struct packed {
      logic [2:0] sync;
      logic [5:0] idx;
      spi_cmd_pkg::cmd_class_t cls;
      logic crc_en;
      logic [7:0] cmd;
      logic [7:0] data;
      logic [7:0] crc;
      logic [7:0] tx;
      logic [15:0] keys;
      logic [23:0] idle;
      logic [spi_cmd_pkg::SETUP_LEN-1:0][7:0] stage;
      logic [spi_cmd_pkg::SETUP_LEN-1:0][7:0] cfg;
      logic [7:0] ctrl_code;
      logic ctrl_v;
      logic apply;
      logic halt;
      logic err;
   } eng_t;

   localparam drv_t DRV_RST = '{miso: 1'h1, oe_n: 1'h1};
   localparam eng_t ENG_RST = '{cls: spi_cmd_pkg::CL_CTRL,
                                tx: spi_cmd_pkg::IDLE_CODE,
                                default: '0};

   logic frame_rst;
   logic [2:0] cnt_r;
   lnk_t lnk_r, lnk_nxt;
   drv_t drv_r, drv_nxt;
   eng_t eng_r, eng_nxt;

   assign frame_rst = rst_i | link.ss_n;

   always_ff @(posedge link.sck or posedge frame_rst) begin
      if (frame_rst) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_r + 3'h1;
      end
   end

   always_comb begin
      lnk_nxt = lnk_r;
      lnk_nxt.sh = {lnk_r.sh[6:0], link.mosi};
      if (cnt_r == spi_cmd_pkg::BIT_LAST) begin
         lnk_nxt.rx = {lnk_r.sh[6:0], link.mosi};
         lnk_nxt.tgl = ~lnk_r.tgl;
      end
   end

   always_ff @(posedge link.sck or posedge rst_i) begin
      if (rst_i) begin
         lnk_r <= '0;
      end else begin
         lnk_r <= lnk_nxt;
      end
   end

   // The outgoing byte is prepared long before the next select, since the
   // host pauses between bytes, so it is steady whenever it is shifted.
   // change on falling
   always_comb begin
      drv_nxt.oe_n = 1'h0;
      drv_nxt.miso = eng_r.tx[~cnt_r];
   end

   always_ff @(negedge link.sck or posedge frame_rst) begin
      if (frame_rst) begin
         drv_r <= DRV_RST;
      end else begin
         drv_r <= drv_nxt;
      end
   end

   assign link.miso_drv = drv_r.miso;
   assign link.miso_oe_n = drv_r.oe_n;

   always_comb begin
      logic [7:0] b;
      logic [7:0] rb;
      logic [5:0] np;
      logic [5:0] nh;
      logic [5:0] rs;
      logic [5:0] rl;
      logic [5:0] k;
      logic ev;
      logic act;
      logic fin;
      b = lnk_r.rx;
      rb = spi_cmd_pkg::NULL_CODE;
      np = eng_r.idx + 6'h01;
      ev = eng_r.sync[2] ^ eng_r.sync[1];
      act = 1'h0;
      fin = 1'h0;
      nh = '0;
      rs = '0;
      rl = '0;
      k = '0;
      eng_nxt = eng_r;
      eng_nxt.sync = {eng_r.sync[1:0], lnk_r.tgl};
      eng_nxt.ctrl_v = 1'h0;
      eng_nxt.apply = 1'h0;
      eng_nxt.err = 1'h0;
      if (eng_r.idx != 6'h00) begin
         eng_nxt.idle = eng_r.idle + 24'h000001;
      end
      if (eng_r.idx != 6'h00 && eng_r.idle == 24'(TIMEOUT_CYC)) begin
         fin = 1'h1;
      end else if (ev) begin
         eng_nxt.idle = '0;
         if (eng_r.idx == 6'h00) begin
            eng_nxt.cmd = b;
            eng_nxt.cls = spi_cmd_pkg::classify(b);
            eng_nxt.crc_en = crc_en_i;
            eng_nxt.crc = spi_cmd_pkg::crc8(CRC_INIT, b, CRC_POLY);
            eng_nxt.keys = key_status_i;
            eng_nxt.halt = (eng_nxt.cls == spi_cmd_pkg::CL_SETUPS);
         end else if (eng_r.idx < spi_cmd_pkg::host_len(eng_r.cls)) begin
            eng_nxt.crc = spi_cmd_pkg::crc8(eng_r.crc, b, CRC_POLY);
            eng_nxt.data = b;
            if (eng_r.cls == spi_cmd_pkg::CL_SETUPS) begin
               eng_nxt.stage[eng_r.idx - 6'h01] = b;
            end
         end else if (eng_r.idx == spi_cmd_pkg::host_len(eng_r.cls) &&
                      eng_r.crc_en) begin
            if (b != eng_r.crc) begin
               eng_nxt.err = 1'h1;
               fin = 1'h1;
            end else begin
               act = 1'h1;
            end
         end
         nh = spi_cmd_pkg::host_len(eng_nxt.cls);
         rs = nh + {5'h00, eng_nxt.crc_en};
         rl = spi_cmd_pkg::resp_len(eng_nxt.cls);
         k = np - rs;
         if (!eng_nxt.crc_en && np == nh) begin
            act = 1'h1;
         end
         if (np == spi_cmd_pkg::total_len(eng_nxt.cls, eng_nxt.crc_en)) begin
            fin = 1'h1;
         end else if (!fin) begin
            eng_nxt.idx = np;
            if (np < nh) begin
               eng_nxt.tx = (eng_nxt.cls == spi_cmd_pkg::CL_SET) ?
                            eng_nxt.cmd : spi_cmd_pkg::IDLE_CODE;
            end else if (np == nh && eng_nxt.crc_en) begin
               eng_nxt.tx = eng_nxt.crc;
            end else if (k < rl) begin
               if (eng_nxt.cls == spi_cmd_pkg::CL_GET) begin
                  rb = eng_nxt.cfg[eng_nxt.cmd[3:0]];
               end else begin
                  rb = (k == 6'h00) ? eng_nxt.keys[7:0] : eng_nxt.keys[15:8];
               end
               eng_nxt.crc = spi_cmd_pkg::crc8(
                  (np == rs) ? CRC_INIT : eng_nxt.crc, rb, CRC_POLY);
               eng_nxt.tx = rb;
            end else begin
               eng_nxt.tx = eng_nxt.crc;
            end
         end
         if (act) begin
            unique case (eng_nxt.cls)
               spi_cmd_pkg::CL_CTRL: begin
                  eng_nxt.ctrl_v = 1'h1;
                  eng_nxt.ctrl_code = eng_nxt.cmd;
               end
               spi_cmd_pkg::CL_SETUPS: begin
                  eng_nxt.cfg = eng_nxt.stage;
                  eng_nxt.apply = 1'h1;
               end
               spi_cmd_pkg::CL_SET: begin
                  eng_nxt.cfg[eng_nxt.cmd[3:0]] = eng_nxt.data;
               end
               default: begin
               end
            endcase
         end
      end
      if (fin) begin
         eng_nxt.idx = '0;
         eng_nxt.tx = spi_cmd_pkg::IDLE_CODE;
         eng_nxt.halt = 1'h0;
         eng_nxt.idle = '0;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         eng_r <= ENG_RST;
      end else begin
         eng_r <= eng_nxt;
      end
   end

   assign ctrl_valid_o = eng_r.ctrl_v;
   assign ctrl_code_o = eng_r.ctrl_code;
   assign sensing_halt_o = eng_r.halt;
   assign setup_apply_o = eng_r.apply;
   assign crc_err_o = eng_r.err;
   assign cfg_o = eng_r.cfg;
endmodule // spi_cmd_device

// ===== hdl/spi_cmd_host.sv
`timescale 1ns/1ps
module spi_cmd_host #(
   parameter logic [7:0] CRC_POLY = spi_cmd_pkg::CRC_POLY_DEF,
   parameter logic [7:0] CRC_INIT = spi_cmd_pkg::CRC_INIT_DEF,
   parameter int GAP_CYC = spi_cmd_pkg::GAP_CYC
) (
   input wire logic clk_i,
   input wire logic rst_i,
   spi_link_if.host link,
   input wire logic crc_en_i,
   input wire logic tx_valid_i,
   input wire logic [7:0] tx_data_i,
   output logic tx_ready_o,
   output logic rsp_valid_o,
   output logic [7:0] rsp_data_o,
   input wire logic rsp_ready_i,
   output logic busy_o,
   output logic done_o,
   output logic crc_err_o
);
   typedef enum logic [2:0] {
      H_IDLE, H_FETCH, H_LEAD, H_LOW, H_HIGH, H_PUSH, H_GAP
   } hst_t;

   typedef struct packed {
      hst_t st;
      logic [5:0] half;
      logic [2:0] bits;
      logic [15:0] gap;
      logic [5:0] idx;
      spi_cmd_pkg::cmd_class_t cls;
      logic crc_en;
      logic [7:0] crc;
      logic [7:0] rcrc;
      logic [7:0] txb;
      logic [7:0] rxb;
      logic [1:0] msync;
      logic sck;
      logic ss_n;
      logic mosi;
      logic rdy;
      logic push;
      logic done;
      logic err;
      logic busy;
   } host_t;

   localparam host_t H_RST = '{st: H_IDLE, cls: spi_cmd_pkg::CL_CTRL,
                               sck: 1'h1, ss_n: 1'h1, mosi: 1'h1,
                               rdy: 1'h1, default: '0};

   host_t q_r, q_nxt;
   logic fifo_rdy;

   always_comb begin
      logic [5:0] nh;
      logic [5:0] rs;
      logic [5:0] rl;
      logic take;
      logic hend;
      nh = spi_cmd_pkg::host_len(q_r.cls);
      rs = nh + {5'h00, q_r.crc_en};
      rl = spi_cmd_pkg::resp_len(q_r.cls);
      take = q_r.rdy && tx_valid_i;
      hend = (q_r.half == 6'(spi_cmd_pkg::SCK_HALF_CYC - 1));
      q_nxt = q_r;
      q_nxt.done = 1'h0;
      q_nxt.msync = {q_r.msync[0], link.miso};
      if (q_r.st == H_LEAD || q_r.st == H_LOW || q_r.st == H_HIGH) begin
         q_nxt.half = hend ? 6'h00 : q_r.half + 6'h01;
      end
      unique case (q_r.st)
         H_IDLE: begin
            if (take) begin
               q_nxt.cls = spi_cmd_pkg::classify(tx_data_i);
               q_nxt.crc_en = crc_en_i;
               q_nxt.crc = spi_cmd_pkg::crc8(CRC_INIT, tx_data_i, CRC_POLY);
               q_nxt.txb = tx_data_i;
               q_nxt.idx = '0;
               q_nxt.rdy = 1'h0;
               q_nxt.busy = 1'h1;
               q_nxt.err = 1'h0;
               q_nxt.st = H_LEAD;
            end
         end
         H_FETCH: begin
            if (take) begin
               q_nxt.crc = spi_cmd_pkg::crc8(q_r.crc, tx_data_i, CRC_POLY);
               q_nxt.txb = tx_data_i;
               q_nxt.rdy = 1'h0;
               q_nxt.st = H_LEAD;
            end
         end
         H_LEAD: begin
            q_nxt.ss_n = 1'h0;
            if (hend) begin
               q_nxt.sck = 1'h0;
               q_nxt.mosi = q_r.txb[7];
               q_nxt.bits = '0;
               q_nxt.st = H_LOW;
            end
         end
         H_LOW: begin
            if (hend) begin
               q_nxt.sck = 1'h1;
               q_nxt.rxb = {q_r.rxb[6:0], q_r.msync[1]};
               q_nxt.st = H_HIGH;
            end
         end
         H_HIGH: begin
            if (hend && q_r.bits == spi_cmd_pkg::BIT_LAST) begin
               q_nxt.ss_n = 1'h1;
               q_nxt.push = 1'h1;
               q_nxt.st = H_PUSH;
            end else if (hend) begin
               q_nxt.bits = q_r.bits + 3'h1;
               q_nxt.sck = 1'h0;
               q_nxt.mosi = q_r.txb[6];
               q_nxt.txb = {q_r.txb[6:0], 1'h0};
               q_nxt.st = H_LOW;
            end
         end
         H_PUSH: begin
            if (fifo_rdy) begin
               q_nxt.push = 1'h0;
               q_nxt.gap = '0;
               q_nxt.st = H_GAP;
               if (q_r.crc_en && q_r.idx == nh && q_r.rxb != q_r.crc) begin
                  q_nxt.err = 1'h1;
               end
               if (q_r.idx >= rs && q_r.idx < rs + rl) begin
                  q_nxt.rcrc = spi_cmd_pkg::crc8(
                     (q_r.idx == rs) ? CRC_INIT : q_r.rcrc, q_r.rxb, CRC_POLY);
               end
               if (q_r.crc_en && rl != 6'h00 && q_r.idx == rs + rl &&
                   q_r.rxb != q_r.rcrc) begin
                  q_nxt.err = 1'h1;
               end
               if (q_r.idx + 6'h01 ==
                   spi_cmd_pkg::total_len(q_r.cls, q_r.crc_en)) begin
                  q_nxt.done = 1'h1;
                  q_nxt.busy = 1'h0;
               end else begin
                  q_nxt.idx = q_r.idx + 6'h01;
               end
            end
         end
         H_GAP: begin
            q_nxt.gap = q_r.gap + 16'h0001;
            if (q_r.gap == 16'(GAP_CYC - 1)) begin
               if (!q_r.busy) begin
                  q_nxt.st = H_IDLE;
                  q_nxt.rdy = 1'h1;
               end else if (q_r.idx < nh) begin
                  q_nxt.st = H_FETCH;
                  q_nxt.rdy = 1'h1;
               end else begin
                  q_nxt.txb = (q_r.crc_en && q_r.idx == nh) ?
                              q_r.crc : spi_cmd_pkg::NULL_CODE;
                  q_nxt.st = H_LEAD;
               end
            end
         end
      endcase
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         q_r <= H_RST;
      end else begin
         q_r <= q_nxt;
      end
   end

   byte_fifo2 #(.WIDTH(8), .DEPTH(2)) u_rsp_fifo (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .in_valid_i(q_r.push),
      .in_data_i(q_r.rxb),
      .in_ready_o(fifo_rdy),
      .out_valid_o(rsp_valid_o),
      .out_data_o(rsp_data_o),
      .out_ready_i(rsp_ready_i)
   );

   assign link.sck = q_r.sck;
   assign link.ss_n = q_r.ss_n;
   assign link.mosi = q_r.mosi;
   assign tx_ready_o = q_r.rdy;
   assign busy_o = q_r.busy;
   assign done_o = q_r.done;
   assign crc_err_o = q_r.err;
endmodule // spi_cmd_host

// ===== sim/spi_link_monitor.sv
`timescale 1ns/1ps
module spi_link_monitor #(
   parameter int GAP_CYC = spi_cmd_pkg::GAP_CYC
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic sck,
   input wire logic ss_n,
   input wire logic mosi,
   input wire logic miso_drv,
   input wire logic miso_oe_n,
   input wire logic miso
);
   logic sck_q_r;
   logic [7:0] hold_r;
   logic [15:0] hi_r;
   logic [3:0] rises_r;

   default clocking mon_cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // The hold and gap counters saturate so that a long idle never wraps into a false short gap.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         sck_q_r <= 1'h1;
         hold_r <= 8'hFF;
         hi_r <= 16'hFFFF;
         rises_r <= 4'h0;
      end else begin
         sck_q_r <= sck;
         hold_r <= (sck != sck_q_r) ? 8'h01 :
            hold_r + {7'h00, hold_r != 8'hFF};
         hi_r <= !ss_n ? 16'h0000 : hi_r + {15'h0000, hi_r != 16'hFFFF};
         rises_r <= ss_n ? 4'h0 : rises_r + {3'h0, sck && !sck_q_r};
      end
   end

   chk_sck_idle_high: assert property (ss_n |-> sck)
      else $error("serial clock low while deselected");
   chk_lead_sck_high: assert property ($fell(ss_n) |-> sck [*8])
      else $error("serial clock fell too soon after select");
   chk_mosi_edge_only: assert property (
      !ss_n && $past(!ss_n) && sck && $past(sck) |-> $stable(mosi))
      else $error("host data changed while clock high");
   chk_miso_edge_only: assert property (
      !ss_n && $past(!ss_n) && sck && $past(sck) |-> $stable(miso))
      else $error("device data changed while clock high");
   chk_half_period_min: assert property (
      !ss_n && sck != sck_q_r |-> hold_r >= 8'(spi_cmd_pkg::SCK_HALF_CYC))
      else $error("serial clock half period too short");
   chk_eight_clocks: assert property ($rose(ss_n) |-> rises_r == 4'h8)
      else $error("select released after wrong clock count");
   chk_byte_gap_min: assert property ($fell(ss_n) |-> hi_r >= 16'(GAP_CYC))
      else $error("byte gap too short");
   chk_miso_released: assert property (ss_n |-> miso_oe_n && miso)
      else $error("device drives data while deselected");
   chk_miso_driven: assert property ($fell(ss_n) |-> ##[0:40] !miso_oe_n)
      else $error("device never drives data in a byte");

   cover property ($rose(ss_n));
   cover property ($fell(miso_oe_n));
   cover property (!miso_oe_n && !miso_drv);
   cover property (!ss_n && sck != sck_q_r);
endmodule // spi_link_monitor

// ===== sim/tb_top.sv
`timescale 1ns/1ps
`define check_eq(g, e) begin \
   n_tests++; \
   if ((g) !== (e)) begin \
      n_errors++; \
      $display("wrong value at %0t: got %h expected %h", $time, g, e); \
   end \
end
module tb_top;
   localparam int GAP = 100;
   localparam int TMO = 2000;
   logic clk_i = 1'h0;
   logic rst_i = 1'h1;
   logic host_crc = 1'h0;
   logic dev_crc = 1'h0;
   logic tx_valid = 1'h0;
   logic [7:0] tx_data = 8'h00;
   logic rsp_ready = 1'h1;
   logic [15:0] key_status = 16'h0000;
   logic tx_ready, rsp_valid, done, host_err, ctrl_valid, halt, apply, dev_err;
   logic busy;
   logic [7:0] rsp_data, ctrl_code;
   logic [spi_cmd_pkg::SETUP_LEN-1:0][7:0] cfg;
   logic [7:0] rx[$];
   logic halt_seen = 1'h0;
   int n_errors = 0;
   int n_tests = 0;
   int n_ctrl = 0;
   int n_apply = 0;
   int n_derr = 0;
   int n_done = 0;

   always #5 clk_i = ~clk_i;

   spi_link_if link_if ();
   spi_cmd_host #(.GAP_CYC(GAP)) i_spi_cmd_host (.clk_i(clk_i), .rst_i(rst_i),
      .link(link_if.host), .crc_en_i(host_crc), .tx_valid_i(tx_valid),
      .tx_data_i(tx_data), .tx_ready_o(tx_ready), .rsp_valid_o(rsp_valid),
      .rsp_data_o(rsp_data), .rsp_ready_i(rsp_ready), .busy_o(busy),
      .done_o(done), .crc_err_o(host_err));
   spi_cmd_device #(.TIMEOUT_CYC(TMO)) i_spi_cmd_device (.clk_i(clk_i),
      .rst_i(rst_i), .link(link_if.device), .crc_en_i(dev_crc),
      .key_status_i(key_status), .ctrl_valid_o(ctrl_valid),
      .ctrl_code_o(ctrl_code), .sensing_halt_o(halt), .setup_apply_o(apply),
      .crc_err_o(dev_err), .cfg_o(cfg));
   spi_link_monitor #(.GAP_CYC(GAP)) i_spi_link_monitor (.clk_i(clk_i),
      .rst_i(rst_i), .sck(link_if.sck), .ss_n(link_if.ss_n),
      .mosi(link_if.mosi), .miso_drv(link_if.miso_drv),
      .miso_oe_n(link_if.miso_oe_n), .miso(link_if.miso));

   always @(posedge clk_i) begin
      if (rsp_valid && rsp_ready) rx.push_back(rsp_data);
      if (ctrl_valid) n_ctrl++;
      if (apply) n_apply++;
      if (dev_err) n_derr++;
      if (done) n_done++;
      if (halt) halt_seen = 1'h1;
   end

   function automatic logic [7:0] crcq(input logic [7:0] q[$]);
      logic [7:0] c;
      c = spi_cmd_pkg::CRC_INIT_DEF;
      foreach (q[i]) begin
         c ^= q[i];
         repeat (8) c = c[7] ? {c[6:0], 1'h0} ^ spi_cmd_pkg::CRC_POLY_DEF :
            {c[6:0], 1'h0};
      end
      return c;
   endfunction

   task automatic conclude();
      $display("compares %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   task automatic guard(input int k);
      if (k >= 50000) begin
         n_errors++;
         $display("timeout at %0t", $time);
         conclude();
      end
   endtask

   task automatic zero();
      n_ctrl = 0;
      n_apply = 0;
      n_derr = 0;
      halt_seen = 1'h0;
   endtask

   // Sends the host bytes, then waits for the host to finish the exchange.
   task automatic xfer(input logic [7:0] b[$], input int stall);
      int k;
      int d0;
      rx.delete();
      d0 = n_done;
      rsp_ready = (stall == 0);
      foreach (b[i]) begin
         k = 0;
         @(negedge clk_i);
         while (tx_ready !== 1'h1 && k < 50000) begin
            @(negedge clk_i);
            k++;
         end
         guard(k);
         tx_valid = 1'h1;
         tx_data = b[i];
         @(negedge clk_i);
         tx_valid = 1'h0;
      end
      k = 0;
      `check_eq(busy, 1'h1)
      while (n_done == d0 && k < 50000) begin
         @(negedge clk_i);
         k++;
         if (k == stall) rsp_ready = 1'h1;
      end
      guard(k);
      `check_eq(busy, 1'h0)
      repeat (GAP + 20) @(negedge clk_i);
   endtask

   task automatic cmp_rx(input logic [7:0] e[$]);
      `check_eq(rx.size(), e.size())
      foreach (e[i]) if (i < rx.size()) `check_eq(rx[i], e[i])
   endtask

   task automatic t_ctrl();
      zero();
      xfer('{8'h20}, 0);
      cmp_rx('{8'h55});
      `check_eq(ctrl_code, 8'h20)
      host_crc = 1'h1;
      dev_crc = 1'h1;
      zero();
      xfer('{8'h21}, 0);
      cmp_rx('{8'h55, crcq('{8'h21})});
      `check_eq(n_ctrl, 1)
      $display("control test done");
   endtask

   task automatic t_set_get();
      xfer('{8'h95, 8'h0C}, 0);
      cmp_rx('{8'h55, 8'h95, crcq('{8'h95, 8'h0C})});
      `check_eq(cfg[5], 8'h0C)
      `check_eq(host_err, 1'h0)
      xfer('{8'hA5}, 0);
      cmp_rx('{8'h55, crcq('{8'hA5}), 8'h0C, crcq('{8'h0C})});
      host_crc = 1'h0;
      dev_crc = 1'h0;
      xfer('{8'h93, 8'hA5}, 0);
      xfer('{8'hA3}, 0);
      cmp_rx('{8'h55, 8'hA5});
      $display("set and get test done");
   endtask

   // The response buffer is left full while the host must wait.
   task automatic t_report();
      key_status = 16'h3C5A;
      host_crc = 1'h1;
      dev_crc = 1'h1;
      xfer('{8'hC1}, 2300);
      cmp_rx('{8'h55, crcq('{8'hC1}), 8'h5A, 8'h3C, crcq('{8'h5A, 8'h3C})});
      $display("report test done");
   endtask

   task automatic t_fault();
      host_crc = 1'h0;
      zero();
      xfer('{8'h96, 8'h77}, 0);
      xfer('{8'h5A}, 0);
      cmp_rx('{crcq('{8'h96, 8'h77})});
      `check_eq(n_derr, 1)
      `check_eq(cfg[6], 8'h00)
      zero();
      xfer('{8'h24}, 0);
      repeat (TMO + 1000) @(negedge clk_i);
      dev_crc = 1'h0;
      xfer('{8'h25}, 0);
      cmp_rx('{8'h55});
      `check_eq(ctrl_code, 8'h25)
      `check_eq(n_ctrl + n_derr, 1)
      host_crc = 1'h1;
      xfer('{8'h22}, 0);
      cmp_rx('{8'h55, 8'h55});
      `check_eq(host_err, 1'h1)
      $display("fault test done");
   endtask

   task automatic t_setup();
      logic [7:0] q[$];
      logic [7:0] e[$];
      q = '{8'h01};
      e = '{8'h55};
      for (int i = 0; i < 42; i++) begin
         q.push_back(8'(i * 5 + 3));
         e.push_back(8'h55);
      end
      e.push_back(crcq(q));
      host_crc = 1'h1;
      dev_crc = 1'h1;
      zero();
      xfer(q, 0);
      cmp_rx(e);
      `check_eq(halt_seen, 1'h1)
      `check_eq(halt, 1'h0)
      `check_eq(n_apply, 1)
      for (int i = 0; i < 42; i++) `check_eq(cfg[i], q[i + 1])
      $display("setup test done");
   endtask

   initial begin
      repeat (3) @(negedge clk_i);
      rst_i = 1'h0;
      t_ctrl();
      t_set_get();
      t_report();
      t_fault();
      t_setup();
      conclude();
   end
endmodule // tb_top
